// ==== byte_fifo.sv ====
// small valid/ready fifo holding register bytes
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire [AW:0] fill = wr_r - rd_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem[rd_r[AW-1:0]];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (flush) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + (AW+1)'(1);
      if (pop) rd_r <= rd_r + (AW+1)'(1);
    end
  end
  always_ff @(posedge clock) begin
    if (push) mem[wr_r[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ==== i2c_ctrl_model.sv ====
// bus controller model: clocks scl, drives sda open drain, pull-up when released
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  input wire logic clock,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // quarter of a 200 ns bit, always just after an edge
  task automatic q;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // works from idle and as a repeated start
  task automatic start;
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
  endtask
  // start then stop with scl never toggling
  task automatic glitch;
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    sda_drv = 1'b1;
    q;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    q;
    scl = 1'b1;
    q;
    r = sda_bus;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic send8(input logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(d[i], x);
    sda_drv = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic a);
    send8(d);
    bit_io(1'b1, a);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, x);
  endtask
endmodule
`default_nettype wire

// ==== i2c_target.sv ====
// i2c target: register address write, repeated-start reads, lock-up watchdog
`timescale 1ns/1ps
`default_nettype none
module i2c_target
  import i2c_target_pkg::*;
#(
  parameter int WDT_SHORT = WDT_SHORT_CYC,
  parameter int WDT_LONG = WDT_LONG_CYC,
  parameter int IDLE_PERF = IDLE_PERF_CYC,
  parameter int IDLE_LOWP = IDLE_LOWP_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  input wire logic address_select_pin,
  input wire logic wdt_enable,
  input wire logic wdt_long_select,
  input wire power_mode_t power_mode,
  output logic [7:0] reg_addr,
  output logic reg_req,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic busy,
  output logic wdt_fired
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d_r;
  logic sda_d_r;
  phase_t st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] start_ptr_r;
  logic [7:0] ptr_r;
  logic sda_low_r;
  logic toggled_r;
  logic [7:0] wr_data_r;
  logic wr_strobe_r;
  logic reg_req_r;
  logic [31:0] wdt_cnt_r;
  logic wdt_fired_r;
  logic [31:0] idle_cnt_r;
  logic [1:0] sel_s;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      sel_s <= 2'b00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      sel_s <= {sel_s[0], address_select_pin};
      scl_d_r <= scl_s[1];
      sda_d_r <= sda_s[1];
    end
  end

  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl && !scl_d_r;
  wire scl_fall = !scl && scl_d_r;
  wire start_cond = scl && scl_d_r && sda_d_r && !sda;
  // a stop with no clock toggle since the start is ignored
  wire stop_seen = scl && scl_d_r && !sda_d_r && sda && toggled_r;
  // base holds the upper address bits; the synchronised strap picks the lowest
  wire [6:0] own_addr = {ADDR_BASE[5:0], sel_s[1]};
  wire byte_done = scl_rise && bit_r == BIT_LAST;
  wire [7:0] rx_byte = {sh_r[6:0], sda};
  wire addr_hit = rx_byte[7:1] == own_addr;
  wire is_write = st_r == ST_ADDR || st_r == ST_REG || st_r == ST_WDATA;
  wire wdt_limit_hit = wdt_cnt_r >= (wdt_long_select ? 32'(WDT_LONG) : 32'(WDT_SHORT));
  // the guard only counts while the target itself is holding sda low
  wire wdt_reset = wdt_enable && sda_low_r && wdt_limit_hit;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out;
  // prefetch from the start so the first read bit never waits on the register file;
  // a write transaction also fetches a few bytes, which the next start discards
  assign fifo_in_valid = st_r == ST_ADDR || st_r == ST_RDATA || st_r == ST_MACK;
  byte_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(start_cond || wdt_reset),
    .in_valid(reg_req_r),
    .in_ready(fifo_in_ready),
    .in_data(reg_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  assign fifo_pop = st_r == ST_MACK && scl_rise && !sda;
  wire want_fetch = fifo_in_valid && fifo_in_ready && !reg_req_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      bit_r <= '0;
      sh_r <= '0;
      start_ptr_r <= PTR_RESET;
      ptr_r <= PTR_RESET;
      sda_low_r <= 1'b0;
      toggled_r <= 1'b0;
      wr_data_r <= '0;
      wr_strobe_r <= 1'b0;
      reg_req_r <= 1'b0;
    end else if (wdt_reset || stop_seen) begin
      st_r <= ST_IDLE;
      sda_low_r <= 1'b0;
      reg_req_r <= 1'b0;
      wr_strobe_r <= 1'b0;
    end else if (start_cond) begin
      st_r <= ST_ADDR;
      bit_r <= '0;
      sda_low_r <= 1'b0;
      toggled_r <= 1'b0;
      reg_req_r <= 1'b0;
      wr_strobe_r <= 1'b0;
      ptr_r <= start_ptr_r;
    end else begin
      wr_strobe_r <= 1'b0;
      reg_req_r <= want_fetch;
      // step only once the byte at the current pointer has been taken
      if (reg_req_r) ptr_r <= ptr_r + 8'h01;
      if (scl_fall) toggled_r <= 1'b1;
      if (st_r != ST_IDLE && scl_rise) begin
        bit_r <= bit_r == BIT_ACK ? 4'h0 : bit_r + 4'h1;
        if (bit_r <= BIT_LAST) sh_r <= rx_byte;
      end
      if (byte_done) begin
        unique case (st_r)
          ST_ADDR: if (!addr_hit) st_r <= ST_IDLE;
          ST_REG: begin
            start_ptr_r <= rx_byte;
            ptr_r <= rx_byte;
          end
          ST_WDATA: begin
            wr_data_r <= rx_byte;
            wr_strobe_r <= 1'b1;
          end
          default: ;
        endcase
      end
      // acknowledge slot is driven low from the fall after bit 8
      if (scl_fall && bit_r == BIT_ACK && is_write) sda_low_r <= 1'b1;
      if (scl_fall && bit_r == 4'h0 && sda_low_r && is_write) begin
        sda_low_r <= 1'b0;
        unique case (st_r)
          ST_ADDR: begin
            st_r <= sh_r[0] ? ST_RDATA : ST_REG;
            // the first data bit goes out on the same fall that ends the ack
            if (sh_r[0]) sda_low_r <= !fifo_out[BIT_LAST[2:0]];
          end
          ST_REG: st_r <= ST_WDATA;
          default: ;
        endcase
      end
      if (st_r == ST_RDATA && scl_fall) begin
        if (bit_r == BIT_ACK) begin
          sda_low_r <= 1'b0;
          st_r <= ST_MACK;
        end else begin
          sda_low_r <= !fifo_out[BIT_LAST[2:0] - bit_r[2:0]];
        end
      end
      if (st_r == ST_MACK && scl_rise) begin
        st_r <= sda ? ST_IDLE : ST_RDATA;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wdt_cnt_r <= '0;
      wdt_fired_r <= 1'b0;
    end else begin
      wdt_fired_r <= wdt_reset;
      wdt_cnt_r <= (sda_low_r && !wdt_reset) ? wdt_cnt_r + 32'd1 : 32'd0;
    end
  end

  // cycles since last write byte, for checking the controller's idle time
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) idle_cnt_r <= 32'hffffffff;
    else if (wr_strobe_r) idle_cnt_r <= '0;
    else if (idle_cnt_r != 32'hffffffff) idle_cnt_r <= idle_cnt_r + 32'd1;
  end
  wire [31:0] idle_need = power_mode == PWR_PERF ? 32'(IDLE_PERF) : 32'(IDLE_LOWP);

  assign sda_oe_n = !sda_low_r;
  assign reg_addr = ptr_r;
  assign reg_req = reg_req_r;
  assign wr_data = wr_data_r;
  assign wr_strobe = wr_strobe_r;
  assign busy = st_r != ST_IDLE;
  assign wdt_fired = wdt_fired_r;

  a_start_ptr_hold: assert property (@(posedge clock) disable iff (!resetn)
    (start_cond && !wdt_reset) |=> ptr_r == $past(start_ptr_r))
    else $error("read not at start pointer");
  a_ptr_step: assert property (@(posedge clock) disable iff (!resetn)
    (reg_req_r && !start_cond && !stop_seen && !wdt_reset && !byte_done)
      |=> ptr_r == $past(ptr_r) + 8'h01) else $error("pointer did not step");
  a_wdt_idle: assert property (@(posedge clock) disable iff (!resetn)
    wdt_reset |=> st_r == ST_IDLE && sda_oe_n) else $error("watchdog left bus held");
  a_nack_release: assert property (@(posedge clock) disable iff (!resetn)
    (st_r == ST_MACK && scl_rise && sda && !wdt_reset) |=> st_r == ST_IDLE)
    else $error("not-acknowledge did not end read");
  a_ack_continue: assert property (@(posedge clock) disable iff (!resetn)
    (st_r == ST_MACK && scl_rise && !sda && !wdt_reset && !stop_seen) |=> st_r == ST_RDATA)
    else $error("acknowledge did not continue read");
  a_wdt_disabled: assert property (@(posedge clock) disable iff (!resetn)
    (sda_low_r && !wdt_enable && !scl_fall && !start_cond && !stop_seen) |=> sda_low_r)
    else $error("held bus released while guard off");
  a_wdt_long_sel: assert property (@(posedge clock) disable iff (!resetn)
    (wdt_enable && wdt_long_select && wdt_cnt_r < 32'(WDT_LONG)) |-> !wdt_reset)
    else $error("long guard period cut short");
  a_pop_valid: assert property (@(posedge clock) disable iff (!resetn)
    fifo_pop |-> fifo_out_valid) else $error("read byte taken from empty buffer");
  a_idle_busy: assert property (@(posedge clock) disable iff (!resetn)
    st_r == ST_IDLE |-> sda_oe_n) else $error("sda driven while idle");
  a_early_stop: assert property (@(posedge clock) disable iff (!resetn)
    (start_cond ##1 (!scl_fall)[*2]) |-> !toggled_r) else $error("toggle seen without clock");
  a_post_write_idle: assert property (@(posedge clock) disable iff (!resetn)
    start_cond |-> idle_cnt_r >= idle_need) else $error("access too soon after write");
endmodule
`default_nettype wire

// ==== i2c_target_pkg.sv ====
// constants for the i2c target with read pointer and lock-up guard
// What this block does
// - write phase: address with write bit, then register byte; target acknowledges both.
// - in read phase controller releases data; target shifts register bytes out.
// - controller acknowledge zero asks for another byte; target continues with next.
// - on not-acknowledge target stops and releases data; controller then stops.
// - register pointer increments after each byte read.
// - each read starts at last written register address, not incremented one.
// - start pointer is 0x00 until any register address is written.
// - watchdog resets interface when the target holds the bus locked.
// - watchdog has an enable bit and a separate timeout select bit.
// - target answers 0x18 with select pin low, 0x19 with pin high.
// - byte receiver pulls data low through acknowledge clock high; transmitter releases.
// - a stop right after a start with no clock toggle is not recognized.
package i2c_target_pkg;
  localparam logic [6:0] ADDR_BASE = 7'h0c;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int CLK_MHZ = 40;
  localparam int IDLE_PERF_US = 2;
  localparam int IDLE_LOWP_US = 450;
  localparam int IDLE_PERF_CYC = IDLE_PERF_US * CLK_MHZ;
  localparam int IDLE_LOWP_CYC = IDLE_LOWP_US * CLK_MHZ;
  localparam int WDT_SHORT_CYC = 2000;
  localparam int WDT_LONG_CYC = 40000;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [1:0] {
    PWR_PERF = 2'b00,
    PWR_LOWP = 2'b01,
    PWR_SUSP = 2'b10
  } power_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_MACK = 3'b101
  } phase_t;
endpackage

// ==== tb_top.sv ====
// testbench: target reads, writes, address match and lock-up guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2c_target_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic address_select_pin = 1'b0;
  logic wdt_enable = 1'b0;
  logic wdt_long_select = 1'b0;
  power_mode_t power_mode = PWR_PERF;
  logic scl, sda_drv, sda_oe_n, reg_req, wr_strobe, busy, wdt_fired, ack;
  logic [7:0] reg_addr, wr_data;
  logic [7:0] wr_last = 8'h00;
  int bad_count = 0;
  int num_checks = 0;
  int n;
  // open drain: any party pulling low wins
  wire sda_bus = sda_drv & sda_oe_n;
  wire [7:0] reg_rdata = reg_addr ^ 8'h5a;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (wr_strobe === 1'b1) wr_last <= wr_data;
  i2c_ctrl_model ctl (.clock(clock), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));
  i2c_target #(.WDT_SHORT(50), .WDT_LONG(100), .IDLE_PERF(80), .IDLE_LOWP(200)) dut (
    .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_bus), .sda_oe_n(sda_oe_n),
    .address_select_pin(address_select_pin), .wdt_enable(wdt_enable),
    .wdt_long_select(wdt_long_select), .power_mode(power_mode), .reg_addr(reg_addr),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .busy(busy), .wdt_fired(wdt_fired));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic setp, input logic [7:0] p,
                    input int cnt, input logic [7:0] first);
    logic k;
    logic [7:0] v;
    if (setp) begin
      ctl.start;
      ctl.wbyte({a, 1'b0}, k);
      chk({7'h0, k}, 8'h00);
      ctl.wbyte(p, k);
      chk({7'h0, k}, 8'h00);
    end
    ctl.start;
    ctl.wbyte({a, 1'b1}, k);
    chk({7'h0, k}, 8'h00);
    chk(reg_addr, first + 8'(FIFO_DEPTH));
    chk({7'h0, reg_req}, 8'h00);
    for (int i = 0; i < cnt; i++) begin
      ctl.rbyte(i == cnt - 1, v);
      chk(v, (first + 8'(i)) ^ 8'h5a);
    end
    ctl.stop;
    chk({7'h0, sda_oe_n}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic k;
    ctl.start;
    ctl.wbyte(8'h30, k);
    ctl.wbyte(p, k);
    ctl.wbyte(v, k);
    chk({7'h0, k}, 8'h00);
    ctl.stop;
    // the controller honours the mode's post-write idle before any access
    repeat (power_mode == PWR_PERF ? 80 : 200) @(posedge clock);
    #1;
    chk(wr_last, v);
  endtask
  // hold scl low in the address ack so the target keeps sda pulled low
  task automatic guard(input logic en, input logic sel, input int lo, input int hi);
    wdt_enable = en;
    wdt_long_select = sel;
    ctl.start;
    ctl.send8(8'h30);
    repeat (8) @(posedge clock);
    #1;
    chk({7'h0, sda_oe_n}, 8'h00);
    n = 0;
    while (wdt_fired !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({7'h0, n >= lo && n <= hi}, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    chk({7'h0, sda_oe_n}, {7'h0, n < 300});
    resetn = 1'b0;
    @(posedge clock);
    #1;
    resetn = 1'b1;
    ctl.stop;
  endtask
  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    chk(reg_addr, 8'h00);
    chk({6'h0, busy, sda_oe_n}, 8'h01);
    repeat (3) @(posedge clock);
    rd(7'h18, 1'b0, 8'h00, 2, 8'h00);
    rd(7'h18, 1'b1, 8'h12, 3, 8'h12);
    rd(7'h18, 1'b0, 8'h00, 2, 8'h12);
    ctl.start;
    ctl.wbyte({7'h19, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01);
    ctl.stop;
    address_select_pin = 1'b1;
    rd(7'h19, 1'b0, 8'h00, 1, 8'h12);
    address_select_pin = 1'b0;
    power_mode = PWR_LOWP;
    wr(8'h20, 8'ha5);
    rd(7'h18, 1'b0, 8'h00, 1, 8'h20);
    power_mode = PWR_PERF;
    wr(8'h30, 8'h3c);
    ctl.glitch;
    repeat (4) @(posedge clock);
    #1;
    chk({7'h0, busy}, 8'h01);
    rd(7'h18, 1'b0, 8'h00, 1, 8'h30);
    guard(1'b0, 1'b0, 300, 300);
    guard(1'b1, 1'b0, 30, 70);
    guard(1'b1, 1'b1, 80, 130);
    finish_test;
  end
  // the sequence needs about 3000 cycles; allow over thirteen times that
  initial begin
    #1000000;
    bad_count++;
    $display("Error at %0t: timeout", $time);
    finish_test;
  end
endmodule
`default_nettype wire
